// ==== page_table_base_regs.sv ====
// Page table base and segment table base registers on AXI4-Lite
//
// Contract
// - Page table base is 64 bits wide or 32 bits narrow.
// - Wide: origin in bits 0-45, 46-58 reserved, size in 59-63.
// - Wide: origin gives upper 46 bits of table address.
// - Wide: at least 11 hash bits, 128-byte groups.
// - Wide: size field counts extra hash bits beyond 11.
// - Size expands into zeros then ones mask.
// - Size above 25 leaves some entry groups unsearched.
// - Narrow: origin bits 0-15, 16-22 reserved, mask 23-31.
// - Narrow: at least 10 hash bits, 64-byte groups.
// - Narrow: mask field holds zeros then ones directly.
// - Segment base: address bits 0-51, 52-63 reserved.
// - Segment base exists only in wide builds.
`timescale 1ns/1ps
`default_nettype none
`include "page_table_cfg.svh"
module page_table_base_regs
  import page_table_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // Write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // Read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Search logic side
  input wire logic [38:0] hash_value,
  output logic [45:0] table_origin,
  output logic [27:0] index_mask,
  output logic [51:0] segment_table_origin,
  output logic [63:0] primary_group_addr,
  output logic [4:0] config_status
);

  // Reserved bits of the base register depend on the layout
  localparam logic [63:0] PTB_WMASK =
    WIDE ? `PTB_W_WMASK : `PTB_N_WMASK;
  localparam logic [63:0] STB_WMASK_C = `STB_WMASK;

  state_t q;
  state_t d;
  logic [27:0] mask_c;
  logic mask_bad_c;
  logic size_illegal_c;
  logic size_unsearched_c;
  logic [63:0] grp_c;
  logic [27:0] org_low;

  // Address decode shared by the read and write paths
  function automatic logic reg_present(input logic [7:0] a,
                                       input logic is_write);
    logic ok;
    ok = 1'b0;
    case (a)
      `OFS_PTB_LO: ok = 1'b1;
      `OFS_PTB_HI: ok = WIDE;
      `OFS_STB_LO: ok = WIDE;
      `OFS_STB_HI: ok = WIDE;
      `OFS_MASK: ok = !is_write;
      `OFS_STATUS: ok = !is_write;
      `OFS_GRP_LO: ok = !is_write;
      `OFS_GRP_HI: ok = !is_write;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Byte lane merge of one 32-bit half
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction

  // Mask expansion from the size or mask field
  index_mask_expand #(
    .WIDE(WIDE)
  ) u_mask (
    .ptb(q.ptb),
    .mask(mask_c),
    .mask_bad(mask_bad_c),
    .size_illegal(size_illegal_c),
    .size_unsearched(size_unsearched_c)
  );

  // Primary entry group address for the current hash
  group_addr_form #(
    .WIDE(WIDE)
  ) u_grp (
    .ptb(q.ptb),
    .mask(mask_c),
    .hash(hash_value),
    .addr(grp_c)
  );

  // Low origin bits that the mask covers
  always_comb
  begin
    if (WIDE)
      org_low = q.ptb[45:18];
    else
      org_low = {19'h0, q.ptb[24:16]};
  end

  // Next state: bus slave, register writes, derived values
  always_comb
  begin
    d = q;

    // Address and data are taken independently, in either order
    if (awvalid && q.awready)
    begin
      d.aw_held = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready)
    begin
      d.w_held = 1'b1;
      d.wdata = wdata;
      d.wstrb = wstrb;
    end
    if (q.bvalid && bready)
      d.bvalid = 1'b0;

    // Write commits once both halves are held
    if (q.aw_held && q.w_held && !q.bvalid)
    begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = reg_present(q.awaddr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      case (q.awaddr)
        `OFS_PTB_LO:
          d.ptb[31:0] = merge(q.ptb[31:0], q.wdata, q.wstrb)
                        & PTB_WMASK[31:0];
        `OFS_PTB_HI:
        begin
          if (WIDE)
            d.ptb[63:32] = merge(q.ptb[63:32], q.wdata, q.wstrb)
                           & PTB_WMASK[63:32];
        end
        `OFS_STB_LO:
        begin
          if (WIDE)
            d.stb[31:0] = merge(q.stb[31:0], q.wdata, q.wstrb)
                          & STB_WMASK_C[31:0];
        end
        `OFS_STB_HI:
        begin
          if (WIDE)
            d.stb[63:32] = merge(q.stb[63:32], q.wdata, q.wstrb);
        end
        default:
          d.ptb = q.ptb;
      endcase
    end

    // Hold off new writes until the response is accepted
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;

    // Read: one request in flight, answered the next cycle
    if (q.rvalid && rready)
      d.rvalid = 1'b0;
    if (arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp = reg_present(araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        `OFS_PTB_LO: d.rdata = q.ptb[31:0];
        `OFS_PTB_HI: d.rdata = WIDE ? q.ptb[63:32] : 32'h0;
        `OFS_STB_LO: d.rdata = WIDE ? q.stb[31:0] : 32'h0;
        `OFS_STB_HI: d.rdata = WIDE ? q.stb[63:32] : 32'h0;
        `OFS_MASK: d.rdata = {4'h0, q.imask};
        `OFS_STATUS: d.rdata = {27'h0, q.stat};
        `OFS_GRP_LO: d.rdata = q.grp[31:0];
        `OFS_GRP_HI: d.rdata = q.grp[63:32];
        default: d.rdata = 32'h0;
      endcase
    end
    d.arready = !d.rvalid;

    // Derived values lag a register write by one cycle
    d.imask = mask_c;
    d.grp = grp_c;
    d.stat.wide_impl = WIDE;
    d.stat.mask_bad = mask_bad_c;
    d.stat.size_illegal = size_illegal_c;
    d.stat.size_unsearched = size_unsearched_c;
    // Flags software that left origin bits set under the mask
    d.stat.origin_misaligned = |(org_low & mask_c);
  end

  // State register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.ptb <= `PTB_RESET;
      q.stb <= `STB_RESET;
      q.bresp <= RESP_OKAY;
      q.rresp <= RESP_OKAY;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign table_origin = WIDE ? q.ptb[63:18] : {30'h0, q.ptb[31:16]};
  assign index_mask = q.imask;
  assign segment_table_origin = q.stb[63:`S_ORG_LSB];
  assign primary_group_addr = q.grp;
  assign config_status = q.stat;

  // Checks on the register contents and derived values
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ptb_reserved_zero_a: assert property ((q.ptb & ~PTB_WMASK) == 64'h0)
    else $error("page table base reserved bits not zero");

  stb_reserved_zero_a: assert property (q.stb[11:0] == 12'h000)
    else $error("segment table base reserved bits not zero");

  stb_absent_a: assert property (!WIDE |-> q.stb == 64'h0)
    else $error("segment table base present in narrow build");

  wide_mask_form_a: assert property (
    WIDE && aresetn && q.ptb[4:0] <= `SIZE_MAX |=>
      ($countones(q.imask) == int'($past(q.ptb[4:0]))) &&
      ((q.imask & (q.imask + 28'h1)) == 28'h0))
    else $error("index mask does not match encoded size");

  narrow_mask_copy_a: assert property (
    !WIDE && aresetn |=> q.imask == {19'h0, $past(q.ptb[8:0])})
    else $error("narrow index mask differs from mask field");

  group_align_a: assert property (
    WIDE ? (q.grp[6:0] == 7'h00) : (q.grp[5:0] == 6'h00))
    else $error("entry group address not group aligned");

  group_form_a: assert property (
    WIDE && aresetn |=> q.grp[63:46] == $past(q.ptb[63:46]) &&
      q.grp[17:7] == $past(hash_value[10:0]))
    else $error("entry group address wrongly formed");

  size_unsearched_a: assert property (
    WIDE && q.ptb[4:0] > `SIZE_SEARCHED |=> q.stat.size_unsearched)
    else $error("unsearched group flag missing");

  write_response_a: assert property (
    q.aw_held && q.w_held && !q.bvalid |=> q.bvalid && !q.aw_held)
    else $error("write response not raised after commit");

  read_answer_a: assert property (
    arvalid && q.arready |=> q.rvalid ##0 !q.arready)
    else $error("read answer not raised one cycle after request");

  // Oversized encoding saturates rather than wrapping the mask
  size_illegal_a: assert property (
    WIDE && aresetn && q.ptb[4:0] > `SIZE_MAX |=>
      q.stat.size_illegal && (q.imask == 28'hfffffff))
    else $error("illegal size not flagged or mask not saturated");

  narrow_width_a: assert property (!WIDE |-> q.ptb[63:32] == 32'h0)
    else $error("narrow page table base holds upper bits");

  narrow_group_form_a: assert property (
    !WIDE |-> (q.grp[63:32] == 32'h0) && (q.grp[5:0] == 6'h00))
    else $error("narrow entry group address out of range");

  narrow_mask_bad_a: assert property (
    !WIDE && aresetn && q.ptb[8:0] == 9'h005 |=> q.stat.mask_bad)
    else $error("malformed narrow mask not flagged");

  // Refused accesses answer with an error and change nothing
  write_refused_a: assert property (
    q.aw_held && q.w_held && !q.bvalid && q.awaddr == `OFS_MASK |=>
      q.bresp == RESP_SLVERR && $stable(q.ptb))
    else $error("write to read-only offset not refused");

  narrow_stb_refused_a: assert property (
    !WIDE && q.aw_held && q.w_held && !q.bvalid && q.awaddr == `OFS_STB_HI |=>
      q.bresp == RESP_SLVERR && q.stb == 64'h0)
    else $error("segment base write accepted in narrow build");

  read_refused_a: assert property (
    arvalid && q.arready && araddr > `OFS_GRP_HI |=>
      q.rresp == RESP_SLVERR && q.rdata == 32'h0)
    else $error("read of unmapped offset not refused");

endmodule // page_table_base_regs
`default_nettype wire

// ==== page_table_cfg.svh ====
// Register offsets, field positions, write masks and reset values
`ifndef PAGE_TABLE_CFG_SVH
`define PAGE_TABLE_CFG_SVH

// Byte offsets on the register bus
`define OFS_PTB_LO 8'h00
`define OFS_PTB_HI 8'h04
`define OFS_STB_LO 8'h08
`define OFS_STB_HI 8'h0c
`define OFS_MASK 8'h10
`define OFS_STATUS 8'h14
`define OFS_GRP_LO 8'h18
`define OFS_GRP_HI 8'h1c

// Wide layout, bit 0 is the least significant bit here
`define W_ORG_MSB 63
`define W_ORG_LSB 18
`define W_SIZE_MSB 4
// Narrow layout
`define N_ORG_MSB 31
`define N_ORG_LSB 16
`define N_MASK_MSB 8
// Segment table base
`define S_ORG_LSB 12

// Writable bits; everything else is reserved
`define PTB_W_WMASK 64'hffff_ffff_fffc_001f
`define PTB_N_WMASK 64'h0000_0000_ffff_01ff
`define STB_WMASK 64'hffff_ffff_ffff_f000

// Reset values
`define PTB_RESET 64'h0000_0000_0000_0000
`define STB_RESET 64'h0000_0000_0000_0000

// Size limits of the encoded size field
`define SIZE_MAX 5'h1c
`define SIZE_SEARCHED 5'h19

`endif

// ==== page_table_pkg.sv ====
// Types shared by the page table base register block
`default_nettype none
package page_table_pkg;

  // AXI response codes
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

  // Configuration health seen by software and the search logic
  typedef struct packed {
    logic origin_misaligned;
    logic size_unsearched;
    logic size_illegal;
    logic mask_bad;
    logic wide_impl;
  } status_t;

  // Whole state of the register block
  typedef struct packed {
    logic [63:0] ptb;
    logic [63:0] stb;
    logic [27:0] imask;
    logic [63:0] grp;
    status_t stat;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    resp_t bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    resp_t rresp;
  } state_t;

endpackage
`default_nettype wire

// ==== index_mask_expand.sv ====
// Expands the size or mask field into the hash index mask
`timescale 1ns/1ps
`default_nettype none
`include "page_table_cfg.svh"
module index_mask_expand #(
  parameter bit WIDE = 1'b1
) (
  // Page table base contents
  input wire logic [63:0] ptb,
  // Derived mask and checks
  output logic [27:0] mask,
  output logic mask_bad,
  output logic size_illegal,
  output logic size_unsearched
);
  logic [28:0] ones;
  logic [8:0] nfield;

  // Size counts extra ones; narrow field is the mask itself
  always_comb
  begin
    ones = (29'h1 << ptb[`W_SIZE_MSB:0]) - 29'h1;
    nfield = ptb[`N_MASK_MSB:0];
    if (WIDE)
    begin
      size_illegal = ptb[`W_SIZE_MSB:0] > `SIZE_MAX;
      mask = size_illegal ? 28'hfffffff : ones[27:0];
      size_unsearched = ptb[`W_SIZE_MSB:0] > `SIZE_SEARCHED;
      mask_bad = 1'b0;
    end
    else
    begin
      mask = {19'h0, nfield};
      mask_bad = |(nfield & (nfield + 9'h1));
      size_illegal = 1'b0;
      size_unsearched = 1'b0;
    end
  end
endmodule // index_mask_expand
`default_nettype wire

// ==== group_addr_form.sv ====
// Forms the primary entry group address from origin, mask and hash
`timescale 1ns/1ps
`default_nettype none
module group_addr_form #(
  parameter bit WIDE = 1'b1
) (
  // Configuration and hash
  input wire logic [63:0] ptb,
  input wire logic [27:0] mask,
  input wire logic [38:0] hash,
  // Entry group address
  output logic [63:0] addr
);
  // Masked upper hash ORed into the low origin bits
  always_comb
  begin
    if (WIDE)
      addr = {ptb[63:46], ptb[45:18] | (hash[38:11] & mask),
              hash[10:0], 7'h00};
    else
      addr = {32'h0, ptb[31:25], ptb[24:16] | (hash[18:10] & mask[8:0]),
              hash[9:0], 6'h00};
  end
endmodule // group_addr_form
`default_nettype wire

// ==== tb_page_table_base_regs.sv ====
// Table-driven bench for the page table base register block
`timescale 1ns/1ps
`default_nettype none
`include "page_table_cfg.svh"
module tb_page_table_base_regs
  import page_table_pkg::*;
;
  // One bus access with the response and read data it should give
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic [1:0] resp;
    logic [31:0] rd;
  } row_t;
  localparam int NROWS = 22;
  localparam row_t ROWS [NROWS] = '{
    '{1'b0, 8'h00, 32'h0, 4'hf, 2'b00, 32'h0},
    '{1'b1, 8'h00, 32'hffffffff, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h00, 32'h0, 4'hf, 2'b00, 32'hfffc001f},
    '{1'b1, 8'h04, 32'h12345678, 4'hf, 2'b00, 32'h0},
    '{1'b1, 8'h04, 32'haaaaaaaa, 4'h2, 2'b00, 32'h0},
    '{1'b0, 8'h04, 32'h0, 4'hf, 2'b00, 32'h1234aa78},
    '{1'b1, 8'h08, 32'hffffffff, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h08, 32'h0, 4'hf, 2'b00, 32'hfffff000},
    '{1'b1, 8'h10, 32'h1, 4'hf, 2'b10, 32'h0},
    '{1'b0, 8'h20, 32'h0, 4'hf, 2'b10, 32'h0},
    '{1'b1, 8'h00, 32'h1d, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h14, 32'h0, 4'hf, 2'b00, 32'h1d},
    '{1'b0, 8'h10, 32'h0, 4'hf, 2'b00, 32'h0fffffff},
    '{1'b1, 8'h00, 32'h1a, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h14, 32'h0, 4'hf, 2'b00, 32'h19},
    '{1'b0, 8'h10, 32'h0, 4'hf, 2'b00, 32'h03ffffff},
    '{1'b1, 8'h00, 32'h19, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h14, 32'h0, 4'hf, 2'b00, 32'h11},
    '{1'b1, 8'h00, 32'h00040003, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h14, 32'h0, 4'hf, 2'b00, 32'h11},
    '{1'b1, 8'h00, 32'h00200003, 4'hf, 2'b00, 32'h0},
    '{1'b0, 8'h14, 32'h0, 4'hf, 2'b00, 32'h01}
  };

  // Clock, reset and bus signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [38:0] hash_value = 39'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [45:0] table_origin;
  logic [27:0] index_mask;
  logic [51:0] segment_table_origin;
  logic [63:0] primary_group_addr;
  logic [4:0] config_status;
  logic [1:0] bresp_narrow;
  logic [31:0] rdata_narrow;
  logic [45:0] table_origin_narrow;
  logic [27:0] index_mask_narrow;
  logic [51:0] segment_table_origin_narrow;
  logic [63:0] primary_group_addr_narrow;
  logic [4:0] config_status_narrow;
  int err_total = 0;
  int samples_checked = 0;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  page_table_base_regs #(.WIDE(1'b1)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .hash_value(hash_value), .table_origin(table_origin), .index_mask(index_mask),
    .segment_table_origin(segment_table_origin),
    .primary_group_addr(primary_group_addr), .config_status(config_status)
  ); // page_table_base_regs

  // Narrow build shares the bus; its handshakes match the wide one cycle for cycle
  page_table_base_regs #(.WIDE(1'b0)) dut_narrow (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(), .wdata(wdata), .wstrb(wstrb),
    .bvalid(), .bready(bready), .bresp(bresp_narrow),
    .arvalid(arvalid), .arready(), .araddr(araddr), .arprot(3'h0),
    .rvalid(), .rready(rready), .rdata(rdata_narrow), .rresp(),
    .hash_value(hash_value), .table_origin(table_origin_narrow),
    .index_mask(index_mask_narrow),
    .segment_table_origin(segment_table_origin_narrow),
    .primary_group_addr(primary_group_addr_narrow),
    .config_status(config_status_narrow)
  ); // page_table_base_regs

  // Address and data offered together, each dropped at its own handshake
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // Read waits for the answer as long as the watchdog allows
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Compare tasks, four-state so an unknown never matches
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_wide(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 140 cycles the run needs
  initial
  begin
    #200000;
    err_total++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    logic [1:0] resp;
    logic [31:0] rdv;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < NROWS; i++)
    begin
      if (ROWS[i].wr)
        bus_write(ROWS[i].addr, ROWS[i].data, ROWS[i].strb, resp);
      else
      begin
        bus_read(ROWS[i].addr, rdv, resp);
        check_word(rdv, ROWS[i].rd);
      end
      check_word({30'h0, resp}, {30'h0, ROWS[i].resp});
    end
    // Size 3 with aligned origin, all-ones hash fills the index
    bus_write(`OFS_PTB_HI, 32'h0, 4'hf, resp);
    bus_write(`OFS_PTB_LO, 32'h3, 4'hf, resp);
    @(posedge aclk);
    hash_value <= 39'h7f_ffff_ffff;
    repeat (2) @(posedge aclk);
    #1;
    check_wide({36'h0, index_mask}, 64'h7);
    check_wide(primary_group_addr, 64'h1fff80);
    check_wide({59'h0, config_status}, 64'h01);
    // Origin supplies the upper address bits
    bus_write(`OFS_PTB_HI, 32'h12345678, 4'hf, resp);
    check_word({30'h0, bresp_narrow}, 32'h2);
    bus_write(`OFS_PTB_LO, 32'h00040000, 4'hf, resp);
    @(posedge aclk);
    hash_value <= 39'h0;
    repeat (2) @(posedge aclk);
    #1;
    check_wide({18'h0, table_origin}, 64'h48d159e0001);
    check_wide(primary_group_addr, 64'h1234567800040000);
    check_wide({12'h0, segment_table_origin}, 64'hfffff);
    // Narrow layout: reserved bits dropped, mask field used directly
    bus_write(`OFS_PTB_LO, 32'h0038fe07, 4'hf, resp);
    bus_read(`OFS_PTB_LO, rdv, resp);
    check_word(rdv, 32'h00380007);
    check_word(rdata_narrow, 32'h00380007);
    @(posedge aclk);
    hash_value <= 39'h7ffff;
    repeat (2) @(posedge aclk);
    #1;
    check_wide({36'h0, index_mask_narrow}, 64'h7);
    check_wide({18'h0, table_origin_narrow}, 64'h38);
    check_wide(primary_group_addr_narrow, 64'h3fffc0);
    check_wide({59'h0, config_status_narrow}, 64'h00);
    check_wide({12'h0, segment_table_origin_narrow}, 64'h0);
    // Segment base is absent from the narrow build only
    bus_write(`OFS_STB_HI, 32'h1, 4'hf, resp);
    check_word({30'h0, resp}, 32'h0);
    check_word({30'h0, bresp_narrow}, 32'h2);
    // Malformed narrow mask is kept as written and flagged
    bus_write(`OFS_PTB_LO, 32'h5, 4'hf, resp);
    @(posedge aclk);
    #1;
    check_wide({36'h0, index_mask_narrow}, 64'h5);
    check_wide({59'h0, config_status_narrow}, 64'h02);
    // Second reset in mid-run clears the registers
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    check_word({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h0);
    aresetn <= 1'b1;
    bus_read(`OFS_PTB_HI, rdv, resp);
    check_word(rdv, 32'h0);
    check_wide({59'h0, config_status}, 64'h01);
    check_wide({59'h0, config_status_narrow}, 64'h00);
    check_wide({12'h0, segment_table_origin}, 64'h0);
    print_verdict();
  end
endmodule // tb_page_table_base_regs
`default_nettype wire
